/* spbs_baud.sv */
/*
  Baud tick selector and rate scaler for modes 1 and 3.
  Assumes timer overflow ticks are one-cycle pulses on the system clock.
*/
`timescale 1ns/1ps
module spbs_baud
  import spbs_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  // Selection
  input  wire spbs_src_t   src_i,
  input  wire logic        double_rate_bit_i,
  input  wire logic        extra_double_rate_bit_i,
  input  wire spbs_ticks_t ticks_i,
  // Output
  output logic             baud_tick_o
);
  logic [1:0] pre_reg;
  logic [1:0] pre_next;
  logic       raw;
  logic [1:0] shift;

  always_comb
  begin
    case (src_i)
      SPBS_SRC_SPLIT_T2: raw = ticks_i.tick_t2;
      SPBS_SRC_BRG:      raw = ticks_i.tick_brg;
      SPBS_SRC_SEC:      raw = ticks_i.tick_sec;
      default:           raw = ticks_i.tick_t1;
    endcase
    // Rate factor: 1, 2 or 4 by dividing less
    if (!extra_double_rate_bit_i)
      shift = 2'd0;
    else if (src_i == SPBS_SRC_SPLIT_T2 && double_rate_bit_i)
      shift = 2'd2;
    else
      shift = 2'd1;
    pre_next = raw ? pre_reg + 2'd1 : pre_reg;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      pre_reg <= 2'd0;
    else
      pre_reg <= pre_next;
  end

  // Pass every 4th, 2nd or each tick
  assign baud_tick_o = raw && ((shift == 2'd2) || (shift == 2'd1 && pre_reg[0])
                       || (pre_reg == 2'd3));
endmodule

/* spbs_pkg.sv */
/*
  Package for the serial port 0 baud source selection and mode 4 SPI master.
  Assumes a byte-wide special-function-register access port from the CPU core.
*/
package spbs_pkg;
  // Register addresses
  localparam logic [7:0] SPBS_ADDR_S0CTL  = 8'h98;
  localparam logic [7:0] SPBS_ADDR_BUF    = 8'h99;
  localparam logic [7:0] SPBS_ADDR_CFG    = 8'h9c;
  localparam logic [7:0] SPBS_ADDR_PWR    = 8'h87;
  // Reset values
  localparam logic [7:0] SPBS_RST_S0CTL   = 8'h00;
  localparam logic [7:0] SPBS_RST_CFG     = 8'h08;
  localparam logic [7:0] SPBS_RST_PWR     = 8'h00;
  // Control register fields
  localparam int SPBS_CTL_MODE0 = 7;
  localparam int SPBS_CTL_MODE1 = 6;
  localparam int SPBS_CTL_TXDONE = 1;
  localparam int SPBS_CTL_RXDONE = 0;
  // Configuration register fields
  localparam int SPBS_CFG_TMRSEL = 7;
  localparam int SPBS_CFG_XDBL   = 6;
  localparam int SPBS_CFG_SPEED  = 5;
  localparam int SPBS_CFG_MODE3  = 4;
  localparam int SPBS_CFG_ORDER  = 3;
  // Power control field
  localparam int SPBS_PWR_DBL    = 7;
  // Shift clock dividers (half periods in system clocks) and bits per transfer
  localparam logic [3:0] SPBS_HALF_SLOW = 4'h6;
  localparam logic [3:0] SPBS_HALF_FAST = 4'h2;
  localparam logic [3:0] SPBS_BITS      = 4'h8;
  // Baud divisors and the SPI mode number
  localparam logic [7:0] SPBS_RELOAD_TOP = 8'hff;
  localparam logic [4:0] SPBS_OVS_DIV    = 5'h10;
  localparam logic [3:0] SPBS_PRE_SLOW   = 4'hc;
  localparam logic [2:0] SPBS_MODE_SPI   = 3'h4;

  typedef enum logic [1:0] {SPBS_SRC_TIMER1, SPBS_SRC_SPLIT_T2, SPBS_SRC_BRG,
                            SPBS_SRC_SEC} spbs_src_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } spbs_sfr_t;

  typedef struct packed {
    logic tick_t2;
    logic tick_t1;
    logic tick_brg;
    logic tick_sec;
  } spbs_ticks_t;
endpackage

/* spbs_spi_slave.sv */
/*
  SPI slave model: returns bit 0 first, collects bits into bit 7 first.
  Assumes slave select held low by the bench for one whole byte.
*/
`timescale 1ns/1ps
module spbs_spi_slave (
  // Bus
  input  wire logic       sclk_i,
  input  wire logic       mosi_i,
  input  wire logic       ss_n_i,
  input  wire logic       cpol_i,
  output logic            miso_o,
  // Data
  input  wire logic [7:0] tx_byte_i,
  output logic [7:0]      rx_byte_o
);
  logic [2:0] n_reg = 3'h0;
  logic       idle_v = 1'b0;
  always @(posedge ss_n_i) idle_v = ~miso_o;
  always @(sclk_i or posedge ss_n_i)
    if (ss_n_i) n_reg = 3'h0;
    else if (sclk_i !== cpol_i) rx_byte_o = {mosi_i, rx_byte_o[7:1]};
    else n_reg = n_reg + 3'h1;
  assign miso_o = ss_n_i ? idle_v : tx_byte_i[n_reg];
endmodule

/* spbs_top.sv */
/*
  Serial port 0 register set, baud source selection and mode 4 SPI master.
  Assumes a byte SFR port, synchronous pins, and the clock pin latch in the port.
*/
`timescale 1ns/1ps
module spbs_top
  import spbs_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  // SFR access
  input  wire spbs_sfr_t   sfr_i,
  output logic [7:0]       sfr_rdata_o,
  // Baud sources
  input  wire logic        transmit_clock_from_timer_i,
  input  wire logic        split_mode_i,
  input  wire spbs_ticks_t ticks_i,
  output logic             baud_tick_o,
  // Pins
  input  wire logic        clk_latch_i,
  input  wire logic        serial_in_pin_i,
  output logic             serial_tx_pin_o,
  output logic             serial_tx_pin_oe_o,
  output logic             serial_rx_pin_o,
  output logic             serial_rx_pin_oe_o,
  // Status
  output logic             spi_busy_o
);
  logic [7:0] ctl_reg, ctl_next, cfg_reg, cfg_next, pwr_reg, pwr_next;
  logic [7:0] buf_reg, buf_next, sh_reg, sh_next;
  logic [3:0] div_reg, div_next, cnt_reg, cnt_next;
  logic       clk_reg, clk_next, mosi_reg, mosi_next;
  typedef enum {SPBS_IDLE, SPBS_LOW, SPBS_HIGH} spbs_state_t;
  spbs_state_t st_reg, st_next;
  logic [2:0] mode;
  logic       spi_mode, lsb_first, wr_buf, done;
  logic [3:0] half;
  spbs_src_t  src;

  function automatic logic out_bit(input logic [7:0] d, input logic lsb);
    out_bit = lsb ? d[0] : d[7];
  endfunction

  assign mode = {cfg_reg[SPBS_CFG_MODE3], ctl_reg[SPBS_CTL_MODE0],
                 ctl_reg[SPBS_CTL_MODE1]};
  assign spi_mode = (mode == SPBS_MODE_SPI);
  assign lsb_first = cfg_reg[SPBS_CFG_ORDER];
  assign half = cfg_reg[SPBS_CFG_SPEED] ? SPBS_HALF_FAST : SPBS_HALF_SLOW;
  assign wr_buf = sfr_i.wr && sfr_i.addr == SPBS_ADDR_BUF;

  always_comb
  begin
    if (transmit_clock_from_timer_i && split_mode_i)
      src = SPBS_SRC_SPLIT_T2;
    else if (cfg_reg[SPBS_CFG_TMRSEL])
      src = SPBS_SRC_SEC;
    else if (!transmit_clock_from_timer_i)
      src = SPBS_SRC_BRG;
    else
      src = SPBS_SRC_TIMER1;
  end

  spbs_baud u_baud (
    .ref_clk_i              (ref_clk_i),
    .reset_n_i              (reset_n_i),
    .src_i                  (src),
    .double_rate_bit_i      (pwr_reg[SPBS_PWR_DBL]),
    .extra_double_rate_bit_i(cfg_reg[SPBS_CFG_XDBL]),
    .ticks_i                (ticks_i),
    .baud_tick_o            (baud_tick_o)
  );

  // SPI engine
  always_comb
  begin
    st_next = st_reg;
    div_next = div_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    clk_next = clk_reg;
    mosi_next = mosi_reg;
    done = 1'b0;
    case (st_reg)
      SPBS_IDLE:
      begin
        clk_next = clk_latch_i;
        if (wr_buf && spi_mode)
        begin
          st_next = SPBS_LOW;
          sh_next = sfr_i.wdata;
          mosi_next = out_bit(sfr_i.wdata, lsb_first);
          div_next = half;
          cnt_next = 4'h0;
        end
      end
      SPBS_LOW:
      begin
        div_next = div_reg - 4'h1;
        if (div_reg == 4'h1)
        begin
          st_next = SPBS_HIGH;
          clk_next = ~clk_reg;
          div_next = half;
          sh_next = lsb_first ? {serial_in_pin_i, sh_reg[7:1]}
                              : {sh_reg[6:0], serial_in_pin_i};
          cnt_next = cnt_reg + 4'h1;
        end
      end
      SPBS_HIGH:
      begin
        div_next = div_reg - 4'h1;
        if (div_reg == 4'h1)
        begin
          clk_next = ~clk_reg;
          div_next = half;
          mosi_next = out_bit(sh_reg, lsb_first);
          if (cnt_reg == SPBS_BITS)
          begin
            st_next = SPBS_IDLE;
            done = 1'b1;
          end
          else
            st_next = SPBS_LOW;
        end
      end
      default:
        st_next = SPBS_IDLE;
    endcase
  end

  // Registers
  always_comb
  begin
    ctl_next = ctl_reg;
    cfg_next = cfg_reg;
    pwr_next = pwr_reg;
    buf_next = buf_reg;
    if (sfr_i.wr && sfr_i.addr == SPBS_ADDR_S0CTL)
      ctl_next = sfr_i.wdata;
    if (sfr_i.wr && sfr_i.addr == SPBS_ADDR_CFG)
      cfg_next = sfr_i.wdata;
    if (sfr_i.wr && sfr_i.addr == SPBS_ADDR_PWR)
      pwr_next = sfr_i.wdata;
    if (spi_mode)
      ctl_next[SPBS_CTL_RXDONE] = 1'b0;
    if (done)
    begin
      ctl_next[SPBS_CTL_TXDONE] = 1'b1;
      buf_next = sh_next;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      ctl_reg  <= SPBS_RST_S0CTL;
      cfg_reg  <= SPBS_RST_CFG;
      pwr_reg  <= SPBS_RST_PWR;
      buf_reg  <= 8'h00;
      sh_reg   <= 8'h00;
      div_reg  <= 4'h0;
      cnt_reg  <= 4'h0;
      clk_reg  <= 1'b0;
      mosi_reg <= 1'b1;
      st_reg   <= SPBS_IDLE;
    end
    else
    begin
      ctl_reg  <= ctl_next;
      cfg_reg  <= cfg_next;
      pwr_reg  <= pwr_next;
      buf_reg  <= buf_next;
      sh_reg   <= sh_next;
      div_reg  <= div_next;
      cnt_reg  <= cnt_next;
      clk_reg  <= clk_next;
      mosi_reg <= mosi_next;
      st_reg   <= st_next;
    end
  end

  always_comb
  begin
    case (sfr_i.addr)
      SPBS_ADDR_S0CTL: sfr_rdata_o = ctl_reg;
      SPBS_ADDR_BUF:   sfr_rdata_o = buf_reg;
      SPBS_ADDR_CFG:   sfr_rdata_o = cfg_reg;
      SPBS_ADDR_PWR:   sfr_rdata_o = pwr_reg;
      default:         sfr_rdata_o = 8'h00;
    endcase
  end

  // Pins driven only in mode 4
  assign serial_tx_pin_o    = clk_reg;
  assign serial_tx_pin_oe_o = spi_mode;
  assign serial_rx_pin_o    = mosi_reg;
  assign serial_rx_pin_oe_o = spi_mode;
  assign spi_busy_o         = (st_reg != SPBS_IDLE);
endmodule

/* spbs_top_assertions.sv */
/*
  Checker for spbs_top: start, timing and flags of mode 4 transfers.
  Assumes one system clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module spbs_top_assertions
  import spbs_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       reset_n_i,
  // SFR access
  input  wire spbs_sfr_t  sfr_i,
  input  wire logic [7:0] sfr_rdata_o,
  // Pins and status
  input  wire logic       clk_latch_i,
  input  wire logic       serial_tx_pin_o,
  input  wire logic       serial_tx_pin_oe_o,
  input  wire logic       serial_rx_pin_o,
  input  wire logic       serial_rx_pin_oe_o,
  input  wire logic       spi_busy_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  wire idle_ok = serial_tx_pin_oe_o && !spi_busy_o;
  a_busy_start: assert property (sfr_i.wr && sfr_i.addr == SPBS_ADDR_BUF
    && idle_ok |=> spi_busy_o) else $error("buffer write did not start");
  a_pin_enables: assert property (serial_tx_pin_oe_o == serial_rx_pin_oe_o
    && (!spi_busy_o || serial_tx_pin_oe_o)) else $error("pin enables differ");
  a_clock_idle: assert property (idle_ok && $past(idle_ok) && $past(reset_n_i)
    |-> serial_tx_pin_o == $past(clk_latch_i)) else $error("clock pin not idle");
  a_busy_min: assert property ($rose(spi_busy_o) |-> spi_busy_o[*8])
    else $error("transfer too short");
  a_busy_bound: assert property ($rose(spi_busy_o) |-> ##[32:96] !spi_busy_o)
    else $error("transfer length out of range");
  a_clock_half: assert property (spi_busy_o && $changed(serial_tx_pin_o)
    |=> $stable(serial_tx_pin_o)) else $error("clock half period too short");
  a_mosi_edge: assert property (spi_busy_o && $past(spi_busy_o)
    && $changed(serial_rx_pin_o) |-> $changed(serial_tx_pin_o)) else $error("data off edge");
  a_rx_quiet: assert property (serial_rx_pin_oe_o && sfr_i.addr == SPBS_ADDR_S0CTL
    |-> !sfr_rdata_o[SPBS_CTL_RXDONE]) else $error("receive flag set");
  a_tx_done: assert property ($fell(spi_busy_o) && sfr_i.addr == SPBS_ADDR_S0CTL
    |-> sfr_rdata_o[SPBS_CTL_TXDONE]) else $error("transmit flag missing");
  c_fast: cover property ($rose(spi_busy_o) ##32 !spi_busy_o);
  c_slow: cover property ($rose(spi_busy_o) ##96 !spi_busy_o);
  c_high: cover property (spi_busy_o && clk_latch_i);
endmodule
bind spbs_top spbs_top_assertions u_chk (.*);

/* test_serial_port_baud_and_spi_master.sv */
/*
  Bench for spbs_top: registers, baud tick selection, SPI transfers.
  Assumes spbs_spi_slave as the far side of the serial pins.
*/
`timescale 1ns/1ps
module test_serial_port_baud_and_spi_master;
  import spbs_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        tcft = 1'b0;
  logic        split = 1'b0;
  logic        latch = 1'b0;
  logic        ss_n = 1'b1;
  spbs_sfr_t   sfr = '0;
  spbs_ticks_t ticks = '0;
  logic [7:0]  sbyte = 8'h00;
  logic [7:0]  rdata, got, w, d;
  logic [7:0]  exp_q [$];
  logic        baud, tx, tx_oe, rx, rx_oe, busy, miso;
  int          fails = 0;
  int          total_checks = 0;
  int          seed = 4946;
  int          n;
  logic [7:0]  ra [5] = '{8'h98, 8'h9c, 8'h87, 8'h99, 8'h55};
  logic [7:0]  rv [5] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00};
  // No reload value driven here, quadruple entry included
  logic [8:0]  bt [7] = '{9'h198, 9'h1a8, 9'h1b8, 9'h002, 9'h022, 9'h041, 9'h104};
  int          be [7] = '{2, 4, 8, 2, 4, 2, 2};
  initial forever #25 clk = ~clk;
  spbs_top u_dut (.ref_clk_i(clk), .reset_n_i(rst_n), .sfr_i(sfr), .sfr_rdata_o(rdata),
    .transmit_clock_from_timer_i(tcft), .split_mode_i(split), .ticks_i(ticks),
    .baud_tick_o(baud), .clk_latch_i(latch), .serial_in_pin_i(miso),
    .serial_tx_pin_o(tx), .serial_tx_pin_oe_o(tx_oe), .serial_rx_pin_o(rx),
    .serial_rx_pin_oe_o(rx_oe), .spi_busy_o(busy));
  wire sclk = tx_oe ? tx : latch;
  wire mosi = rx_oe ? rx : 1'b1;
  spbs_spi_slave u_slave (.sclk_i(sclk), .mosi_i(mosi), .ss_n_i(ss_n), .cpol_i(latch),
    .miso_o(miso), .tx_byte_i(sbyte), .rx_byte_o(got));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    sfr <= '{1'b1, 1'b0, a, v};
    @(posedge clk);
    sfr <= '{1'b0, 1'b0, SPBS_ADDR_S0CTL, 8'h00};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    sfr.addr <= a;
    #1 v = rdata;
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v, input logic keep);
    for (int i = 0; i < 8; i++) rev[i] = keep ? v[i] : v[7 - i];
  endfunction
  task results;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ra[i])
    begin
      rd(ra[i], d);
      chk(d, rv[i]);
    end
    foreach (bt[i])
    begin
      wr(SPBS_ADDR_CFG, {bt[i][6:5], 6'h08});
      wr(SPBS_ADDR_PWR, {bt[i][4], 7'h00});
      tcft <= bt[i][8];
      split <= bt[i][7];
      n = 0;
      for (int k = 0; k < 16; k++)
      begin
        @(posedge clk);
        ticks <= k[0] ? ~bt[i][3:0] : bt[i][3:0];
        #1 n += baud;
      end
      @(posedge clk);
      ticks <= '0;
      chk(n[7:0], be[i][7:0]);
      rd(SPBS_ADDR_CFG, d);
      chk(d, {bt[i][6:5], 6'h08});
      rd(SPBS_ADDR_PWR, d);
      chk(d, {bt[i][4], 7'h00});
    end
    for (int m = 0; m < 8; m++)
    begin
      w = 8'($random(seed));
      wr(SPBS_ADDR_CFG, {2'b00, m[0], 1'b1, m[1], 3'h0});
      latch <= m[2];
      sbyte <= 8'($random(seed));
      wr(SPBS_ADDR_S0CTL, 8'h01);
      exp_q.push_back(rev(w, m[1]));
      exp_q.push_back(rev(sbyte, m[1]));
      chk({7'h00, tx}, {7'h00, latch});
      ss_n <= 1'b0;
      wr(SPBS_ADDR_BUF, w);
      n = 0;
      do
      begin
        @(posedge clk);
        #1 n++;
      end
      while (rdata[1] !== 1'b1 && n < 200);
      chk(n[7:0], {m[0] ? SPBS_HALF_FAST : SPBS_HALF_SLOW, 4'h0});
      if (n > 199)
        break;
      @(posedge clk);
      ss_n <= 1'b1;
      chk(got, exp_q.pop_front());
      rd(SPBS_ADDR_BUF, d);
      chk(d, exp_q.pop_front());
      rd(SPBS_ADDR_S0CTL, d);
      chk(d, 8'h02);
    end
    results();
  end
endmodule
